// >>> hdl/tlrb_pkg.sv
// Shared constants for the transmit length and antenna trim register bank.
// Assumes a single 100 MHz clock domain and an AHB-Lite register port.
package tlrb_pkg;

    // ========================================================
    // Register indices (byte address is four times the index)
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_CNT_HIGH = 8'h1d;
    localparam logic [7:0] IDX_CNT_LOW = 8'h1e;
    localparam logic [7:0] IDX_RATE = 8'h1f;
    localparam logic [7:0] IDX_ADC = 8'h20;
    localparam logic [7:0] IDX_TRIM = 8'h21;
    localparam logic [7:0] IDX_CAL_DISP = 8'h23;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam int ADDR_IDX_LSB = 2;

    // ========================================================
    // Field layout
    localparam int CNT_W = 13;
    localparam int CNT_HIGH_W = 8;
    localparam int CNT_LOW_W = 5;
    localparam int CNT_LOW_LSB = 3;
    localparam int SPLIT_W = 3;
    localparam int RATE_W = 4;
    localparam int RATE_LSB = 4;
    localparam int TRIM_W = 4;
    localparam int TRIM_SEL_BIT = 7;
    localparam int TRIM_MAN_LSB = 3;
    localparam int CAL_TRIM_LSB = 4;
    localparam int CAL_ERR_BIT = 3;
    localparam logic [2:0] SPLIT_NONE = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ========================================================
    // Interrupt status bits
    localparam int IRQ_N = 4;
    localparam int IRQ_PAR = 0;
    localparam int IRQ_CAL = 1;
    localparam int IRQ_ADC = 2;
    localparam int IRQ_RATE = 3;

    // ========================================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : tlrb_pkg

// >>> hdl/tlrb_ahb_front.sv
// AHB-Lite slave front end: qualifies address phases, holds a write for its data phase.
// Assumes one slave on the bus, zero wait states, word-only accesses.
`timescale 1ns/1ps
module tlrb_ahb_front
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic rd_req,
    output logic [7:0] rd_idx,
    output logic wr_en,
    output logic [7:0] wr_idx,
    output logic hreadyout,
    output logic hresp
);
    import tlrb_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_idx;
    } tlrb_front_s;

    tlrb_front_s state_reg;
    tlrb_front_s state_next;
    logic acc_ok;

    // Anything but an aligned word inside the low window reads zero
    assign acc_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD)
                    && (haddr[ADDR_IDX_LSB-1:0] == '0) && (haddr[31:ADDR_IDX_LSB+IDX_W] == '0);
    assign rd_idx = haddr[ADDR_IDX_LSB +: IDX_W];
    assign rd_req = acc_ok && !hwrite;
    assign wr_en = state_reg.wr_pend;
    assign wr_idx = state_reg.wr_idx;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    always_comb
    begin
        state_next = state_reg;
        state_next.wr_pend = acc_ok && hwrite;
        state_next.wr_idx = haddr[ADDR_IDX_LSB +: IDX_W];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule : tlrb_ahb_front

// >>> hdl/tlrb_trim_drive.sv
// Antenna trim switch driver: picks manual or calibrated trim and drives both pin groups.
// Assumes selection and trim values come from registers on the same clock.
`timescale 1ns/1ps
module tlrb_trim_drive
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic trim_sel,
    input wire logic [3:0] trim_manual,
    input wire logic [3:0] trim_calib,
    output logic [3:0] trim_group_one_pins,
    output logic [3:0] trim_group_two_pins
);
    import tlrb_pkg::*;

    typedef struct packed {
        logic [3:0] one;
        logic [3:0] two;
    } tlrb_trim_s;

    tlrb_trim_s state_reg;
    tlrb_trim_s state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.one = trim_sel ? trim_manual : trim_calib;
        state_next.two = trim_sel ? trim_manual : trim_calib;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign trim_group_one_pins = state_reg.one;
    assign trim_group_two_pins = state_reg.two;

endmodule : tlrb_trim_drive

// >>> hdl/tlrb_tx_length_trim.sv
// Transmit length, split-byte, bit-rate, conversion and antenna trim register bank.
// Assumes an AHB-Lite master on hclk; command decoder, A/D, rate detector and
// calibration logic all sit on the same clock and hand in one-cycle strobes.
//
// Function
// - 13-bit byte count spans two registers
// - Low three bits give split-byte bit count
// - Split byte used only for Type A
// - Nonzero split byte disables parity generation
// - Wake-up-all with anticollision, card idle and nonzero split raises parity error
// - Upper nibble shows detected active bit rate
// - Read-only register shows last conversion result
// - Trim source bit picks calibration or manual
// - Manual trim bits switch both pin groups
// - Writable registers default to zero
// - Display registers clear to zero
// - Calibration result stored, drives trim when selected
`timescale 1ns/1ps
module tlrb_tx_length_trim
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic set_default,
    input wire logic type_a_mode,
    input wire logic anticoll_enable,
    input wire logic card_idle,
    input wire logic wupa_cmd,
    input wire logic rate_valid,
    input wire logic [3:0] rate_value,
    input wire logic adc_valid,
    input wire logic [7:0] adc_value,
    input wire logic calib_done,
    input wire logic [3:0] calib_trim,
    input wire logic calib_err,
    output logic [12:0] tx_byte_count,
    output logic [2:0] tx_split_bits,
    output logic tx_parity_enable,
    output logic irq,
    output logic [3:0] trim_group_one_pins,
    output logic [3:0] trim_group_two_pins
);
    import tlrb_pkg::*;

    // ========================================================
    // State
    typedef struct packed {
        logic [CNT_HIGH_W-1:0] cnt_high;
        logic [CNT_LOW_W-1:0] cnt_low;
        logic [SPLIT_W-1:0] split;
        logic [SPLIT_W-1:0] split_eff;
        logic par_en;
        logic [RATE_W-1:0] rate;
        logic [7:0] adc;
        logic trim_sel;
        logic [TRIM_W-1:0] trim_man;
        logic [TRIM_W-1:0] cal_trim;
        logic cal_err;
        logic [IRQ_N-1:0] irq_status;
        logic [IRQ_N-1:0] irq_mask;
        logic irq;
        logic [31:0] hrdata;
    } tlrb_state_s;

    tlrb_state_s state_reg;
    tlrb_state_s state_next;
    // Split count resets to none, so parity generation must come out of reset enabled
    localparam tlrb_state_s STATE_RESET = '{par_en: 1'b1, default: '0};
    logic rd_req;
    logic [7:0] rd_idx;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wbyte;
    logic par_evt;
    logic [IRQ_N-1:0] evt;

    // ========================================================
    // Register view: unused bit positions are simply not stored
    function automatic logic [7:0] reg_view(input logic [7:0] idx, input tlrb_state_s s);
        logic [7:0] v;
        v = BYTE_ZERO;
        case (idx)
            IDX_CNT_HIGH: v = s.cnt_high;
            IDX_CNT_LOW: v = {s.cnt_low, s.split};
            IDX_RATE: v[RATE_LSB +: RATE_W] = s.rate;
            IDX_ADC: v = s.adc;
            IDX_TRIM:
            begin
                v[TRIM_SEL_BIT] = s.trim_sel;
                v[TRIM_MAN_LSB +: TRIM_W] = s.trim_man;
            end
            IDX_CAL_DISP:
            begin
                v[CAL_TRIM_LSB +: TRIM_W] = s.cal_trim;
                v[CAL_ERR_BIT] = s.cal_err;
            end
            IDX_IRQ_STAT: v[IRQ_N-1:0] = s.irq_status;
            IDX_IRQ_MASK: v[IRQ_N-1:0] = s.irq_mask;
            default: v = BYTE_ZERO;
        endcase
        return v;
    endfunction : reg_view

    // ========================================================
    // Bus front end and trim driver
    tlrb_ahb_front u_front
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .rd_req(rd_req),
        .rd_idx(rd_idx),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .hreadyout(hreadyout),
        .hresp(hresp)
    );

    tlrb_trim_drive u_trim
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .trim_sel(state_reg.trim_sel),
        .trim_manual(state_reg.trim_man),
        .trim_calib(state_reg.cal_trim),
        .trim_group_one_pins(trim_group_one_pins),
        .trim_group_two_pins(trim_group_two_pins)
    );

    assign wbyte = hwdata[7:0];

    // Wake-up-all with a partial last byte armed cannot frame correctly
    assign par_evt = wupa_cmd && anticoll_enable && card_idle
                     && (state_reg.split != SPLIT_NONE);

    // ========================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        evt = '0;
        evt[IRQ_PAR] = par_evt;
        evt[IRQ_CAL] = calib_done;
        evt[IRQ_ADC] = adc_valid;
        evt[IRQ_RATE] = rate_valid;
        if (wr_en)
        begin
            case (wr_idx)
                IDX_CNT_HIGH: state_next.cnt_high = wbyte;
                IDX_CNT_LOW:
                begin
                    state_next.cnt_low = wbyte[CNT_LOW_LSB +: CNT_LOW_W];
                    state_next.split = wbyte[SPLIT_W-1:0];
                end
                IDX_TRIM:
                begin
                    state_next.trim_sel = wbyte[TRIM_SEL_BIT];
                    state_next.trim_man = wbyte[TRIM_MAN_LSB +: TRIM_W];
                end
                IDX_IRQ_STAT: state_next.irq_status = state_reg.irq_status & ~wbyte[IRQ_N-1:0];
                IDX_IRQ_MASK: state_next.irq_mask = wbyte[IRQ_N-1:0];
                default: state_next.irq_mask = state_next.irq_mask;
            endcase
        end
        if (rate_valid)
        begin
            state_next.rate = rate_value;
        end
        if (adc_valid)
        begin
            state_next.adc = adc_value;
        end
        if (calib_done)
        begin
            state_next.cal_trim = calib_trim;
            state_next.cal_err = calib_err;
        end
        // A new event beats a clear written in the same cycle
        state_next.irq_status = state_next.irq_status | evt;
        if (set_default)
        begin
            state_next.cnt_high = '0;
            state_next.cnt_low = '0;
            state_next.split = '0;
            state_next.trim_sel = 1'b0;
            state_next.trim_man = '0;
            state_next.rate = '0;
            state_next.adc = '0;
            state_next.cal_trim = '0;
            state_next.cal_err = 1'b0;
        end
        // Split byte only counts in Type A framing, and then parity is off
        state_next.split_eff = type_a_mode ? state_next.split : SPLIT_NONE;
        state_next.par_en = (state_next.split_eff == SPLIT_NONE);
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
        // Read from the post-write view so back-to-back write then read agrees
        state_next.hrdata = '0;
        if (rd_req)
        begin
            state_next.hrdata[7:0] = reg_view(rd_idx, state_next);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ========================================================
    // Outputs
    assign tx_byte_count = {state_reg.cnt_high, state_reg.cnt_low};
    assign tx_split_bits = state_reg.split_eff;
    assign tx_parity_enable = state_reg.par_en;
    assign irq = state_reg.irq;
    assign hrdata = state_reg.hrdata;

    // ========================================================
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_cnt_high_write;
        wr_en && (wr_idx == IDX_CNT_HIGH) && !set_default;
    endsequence

    sequence s_manual_write;
        wr_en && (wr_idx == IDX_TRIM) && wbyte[TRIM_SEL_BIT] && !set_default;
    endsequence

    sequence s_quiet_trim;
        !set_default && !(wr_en && (wr_idx == IDX_TRIM));
    endsequence

    property p_count_upper;
        s_cnt_high_write |=> tx_byte_count[CNT_W-1 -: CNT_HIGH_W] == $past(wbyte);
    endproperty
    a_count_upper: assert property (p_count_upper) else $error("byte count upper bits wrong");

    property p_split_write;
        wr_en && (wr_idx == IDX_CNT_LOW) && !set_default
            |=> (state_reg.split == $past(wbyte[SPLIT_W-1:0]))
                && (tx_byte_count[CNT_LOW_W-1:0] == $past(wbyte[CNT_LOW_LSB +: CNT_LOW_W]));
    endproperty
    a_split_write: assert property (p_split_write) else $error("split or low count not stored");

    property p_type_a_only;
        !type_a_mode |=> tx_split_bits == SPLIT_NONE;
    endproperty
    a_type_a_only: assert property (p_type_a_only) else $error("split byte outside Type A");

    property p_parity_off;
        tx_parity_enable == (tx_split_bits == SPLIT_NONE);
    endproperty
    a_parity_off: assert property (p_parity_off) else $error("parity enable disagrees with split");

    property p_wupa_parity;
        par_evt |=> state_reg.irq_status[IRQ_PAR]
            && (irq == state_reg.irq_mask[IRQ_PAR] || irq);
    endproperty
    a_wupa_parity: assert property (p_wupa_parity) else $error("parity error event lost");

    property p_rate_capture;
        rate_valid && !set_default |=> state_reg.rate == $past(rate_value);
    endproperty
    a_rate_capture: assert property (p_rate_capture) else $error("bit rate not captured");

    property p_adc_capture;
        adc_valid && !set_default |=> state_reg.adc == $past(adc_value);
    endproperty
    a_adc_capture: assert property (p_adc_capture) else $error("conversion result not captured");

    property p_manual_trim;
        s_manual_write ##1 s_quiet_trim
            |=> (trim_group_one_pins == $past(wbyte[TRIM_MAN_LSB +: TRIM_W], 2))
                && (trim_group_two_pins == $past(wbyte[TRIM_MAN_LSB +: TRIM_W], 2));
    endproperty
    a_manual_trim: assert property (p_manual_trim) else $error("manual trim not on pins");

    property p_calib_trim;
        !state_reg.trim_sel |=> trim_group_one_pins == $past(state_reg.cal_trim)
            && trim_group_two_pins == $past(state_reg.cal_trim);
    endproperty
    a_calib_trim: assert property (p_calib_trim) else $error("calibrated trim not on pins");

    property p_calib_store;
        calib_done && !set_default ##1 rd_req && (rd_idx == IDX_CAL_DISP) && !calib_done
            |=> hrdata[CAL_TRIM_LSB +: TRIM_W] == $past(calib_trim, 2);
    endproperty
    a_calib_store: assert property (p_calib_store) else $error("calibration result not readable");

    property p_defaults;
        set_default |=> (tx_byte_count == '0) && (state_reg.split == SPLIT_NONE)
            && !state_reg.trim_sel && (state_reg.trim_man == '0);
    endproperty
    a_defaults: assert property (p_defaults) else $error("writable registers not defaulted");

    property p_display_clear;
        set_default |=> (state_reg.rate == '0) && (state_reg.adc == '0) && (state_reg.cal_trim == '0);
    endproperty
    a_display_clear: assert property (p_display_clear) else $error("display registers not cleared");

    property p_unused_zero;
        rd_req && ((rd_idx == IDX_RATE) || (rd_idx == IDX_TRIM))
            |=> (hrdata[TRIM_MAN_LSB-1:0] == '0) && (hrdata[31:8] == '0)
                && (($past(rd_idx) != IDX_RATE) || (hrdata[RATE_LSB-1:0] == '0));
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

    property p_calib_capture;
        calib_done && !set_default |=> (state_reg.cal_trim == $past(calib_trim))
            && (state_reg.cal_err == $past(calib_err));
    endproperty
    a_calib_capture: assert property (p_calib_capture) else $error("calibration result not stored");

    property p_count_hold;
        !set_default && !(wr_en && ((wr_idx == IDX_CNT_HIGH) || (wr_idx == IDX_CNT_LOW)))
            |=> $stable(tx_byte_count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("byte count changed without a write");

endmodule : tlrb_tx_length_trim

// >>> testbench/tlrb_host_model.sv
// Host model: an AHB-Lite master issuing single whole-word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
module tlrb_host_model
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    import tlrb_pkg::*;

    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
    end

    // ========================================================
    // One transfer; no wait count assumed, only the bench timeout ends a wait
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            @(posedge hclk);
        end
        rd = hrdata;
        // Released data lines must not keep showing the old value
        hwdata <= ~wd;
    endtask : xfer
endmodule : tlrb_host_model

// >>> testbench/tlrb_tx_length_trim_tb.sv
// Self-checking bench for the transmit length and trim register bank.
// Assumes the host model drives the register port; bench drives the event strobes.
`timescale 1ns/1ps
module tlrb_tx_length_trim_tb;
    import tlrb_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq, tx_parity_enable;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, tx_split_bits;
    logic [12:0] tx_byte_count;
    logic [3:0] trim_group_one_pins, trim_group_two_pins;
    logic set_default = 1'b0, type_a_mode = 1'b0, anticoll_enable = 1'b0, card_idle = 1'b0;
    logic wupa_cmd = 1'b0, rate_valid = 1'b0, adc_valid = 1'b0, calib_done = 1'b0, calib_err = 1'b0;
    logic [3:0] rate_value = 4'h0, calib_trim = 4'h0;
    logic [7:0] adc_value = 8'h00;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 hclk = ~hclk;

    tlrb_tx_length_trim u_tlrb_tx_length_trim (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .set_default(set_default), .type_a_mode(type_a_mode),
        .anticoll_enable(anticoll_enable), .card_idle(card_idle), .wupa_cmd(wupa_cmd), .rate_valid(rate_valid),
        .rate_value(rate_value), .adc_valid(adc_valid), .adc_value(adc_value), .calib_done(calib_done),
        .calib_trim(calib_trim), .calib_err(calib_err), .tx_byte_count(tx_byte_count),
        .tx_split_bits(tx_split_bits), .tx_parity_enable(tx_parity_enable), .irq(irq),
        .trim_group_one_pins(trim_group_one_pins), .trim_group_two_pins(trim_group_two_pins));

    tlrb_host_model u_tlrb_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ========================================================
    // Shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        u_tlrb_host_model.xfer(1'b1, idx, {24'h0, d}, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        u_tlrb_host_model.xfer(1'b0, idx, 32'h0, r);
        check(r, {24'h0, exp});
    endtask : rd_chk

    // Samples after the edge's updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : settle

    task automatic pins_chk(input logic [3:0] exp);
        settle(3);
        check(trim_group_one_pins, exp);
        check(trim_group_two_pins, exp);
    endtask : pins_chk

    task automatic pulse_wupa();
        @(posedge hclk);
        wupa_cmd <= 1'b1;
        @(posedge hclk);
        wupa_cmd <= 1'b0;
    endtask : pulse_wupa

    task automatic close_out();
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // ========================================================
    // Scenarios
    task automatic t_defaults();
        logic [7:0] regs [6] = '{IDX_CNT_HIGH, IDX_CNT_LOW, IDX_RATE, IDX_ADC, IDX_TRIM, IDX_CAL_DISP};
        foreach (regs[i])
            rd_chk(regs[i], 8'h00);
        check(tx_byte_count, 13'h0000);
        check(tx_parity_enable, 1'b1);
        check(hresp, HRESP_OKAY);
        pins_chk(4'h0);
    endtask : t_defaults

    task automatic t_count();
        @(posedge hclk);
        type_a_mode <= 1'b1;
        wr(IDX_CNT_HIGH, 8'hff);
        wr(IDX_CNT_LOW, 8'hff);
        settle(2);
        check(tx_byte_count, 13'h1fff);
        check(tx_split_bits, 3'h7);
        check(tx_parity_enable, 1'b0);
        rd_chk(IDX_CNT_LOW, 8'hff);
        wr(IDX_CNT_HIGH, 8'h96);
        wr(IDX_CNT_LOW, 8'h68);
        settle(2);
        check(tx_byte_count, 13'h12cd);
        check(tx_split_bits, 3'h0);
        check(tx_parity_enable, 1'b1);
        wr(IDX_CNT_LOW, 8'h03);
        type_a_mode <= 1'b0;
        settle(2);
        check(tx_split_bits, 3'h0);
        @(posedge hclk);
        type_a_mode <= 1'b1;
        settle(2);
        check(tx_split_bits, 3'h3);
    endtask : t_count

    task automatic t_wakeup_irq();
        wr(IDX_IRQ_MASK, 8'h0f);
        wr(IDX_CNT_LOW, 8'hf8);
        anticoll_enable <= 1'b1;
        card_idle <= 1'b1;
        pulse_wupa();
        rd_chk(IDX_IRQ_STAT, 8'h00);
        wr(IDX_CNT_LOW, 8'h01);
        pulse_wupa();
        settle(3);
        check(irq, 1'b1);
        rd_chk(IDX_IRQ_STAT, 8'h01);
        wr(IDX_IRQ_STAT, 8'h01);
        settle(3);
        check(irq, 1'b0);
        wr(IDX_IRQ_MASK, 8'h00);
        pulse_wupa();
        settle(3);
        check(irq, 1'b0);
        rd_chk(IDX_IRQ_STAT, 8'h01);
        // Clear and a fresh event land on the same edge: the event must survive
        fork
            wr(IDX_IRQ_STAT, 8'h01);
            begin
                repeat (2) @(posedge hclk);
                wupa_cmd <= 1'b1;
                @(posedge hclk);
                wupa_cmd <= 1'b0;
            end
        join
        rd_chk(IDX_IRQ_STAT, 8'h01);
        wr(IDX_IRQ_STAT, 8'h01);
        rd_chk(IDX_IRQ_STAT, 8'h00);
    endtask : t_wakeup_irq

    task automatic t_displays_trim();
        @(posedge hclk);
        rate_valid <= 1'b1;
        rate_value <= 4'ha;
        adc_valid <= 1'b1;
        adc_value <= 8'h5a;
        calib_done <= 1'b1;
        calib_trim <= 4'h9;
        calib_err <= 1'b1;
        // Read the display in the cycle right after the strobe
        fork
            rd_chk(IDX_CAL_DISP, 8'h98);
            begin
                @(posedge hclk);
                rate_valid <= 1'b0;
                adc_valid <= 1'b0;
                calib_done <= 1'b0;
            end
        join
        rd_chk(IDX_RATE, 8'ha0);
        rd_chk(IDX_ADC, 8'h5a);
        rd_chk(IDX_IRQ_STAT, 8'h0e);
        wr(IDX_IRQ_STAT, 8'h0e);
        rd_chk(IDX_IRQ_STAT, 8'h00);
        wr(IDX_RATE, 8'hff);
        rd_chk(IDX_RATE, 8'ha0);
        rd_chk(8'h22, 8'h00);
        pins_chk(4'h9);
        wr(IDX_TRIM, 8'hff);
        rd_chk(IDX_TRIM, 8'hf8);
        pins_chk(4'hf);
        wr(IDX_TRIM, 8'ha8);
        pins_chk(4'h5);
        wr(IDX_TRIM, 8'h28);
        pins_chk(4'h9);
        @(posedge hclk);
        set_default <= 1'b1;
        @(posedge hclk);
        set_default <= 1'b0;
    endtask : t_displays_trim

    // ========================================================
    // Main sequence and hang guard
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            close_out();
        end
    end

    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_defaults();
        t_count();
        t_wakeup_irq();
        t_displays_trim();
        t_defaults();
        close_out();
    end
endmodule : tlrb_tx_length_trim_tb
